// ===== logic/dmsr_regs.sv
// Sequencer register bank: indexed host port, reset control, clocking and plane masks
`timescale 1ns/1ps
`include "dmsr_defines.svh"
// Functional notes
// (R1) Host writes an index at the index port, then uses the data port.
// (R2) Three-bit pointer; values 0 to 4 pick the five sequencer registers.
// (R3) Index port read returns the I/O address select copy in bit 5.
// (R4) Index port read returns monochrome configuration bits 0 and 1 in bits 6, 7.
// (R5) Reset bit 0 low halts at once and floats memory control outputs.
// (R6) Reset bit 1 low clears the sequencer on the clock and halts it.
// (R7) Sequencer runs only while both reset bits are one.
// (R8) Software applies synchronous reset before changing the clocking mode.
// (R9) Clocking bit 0 picks eight dots per character, else nine.
// (R10) Clocking bit 1 selects the low refresh bandwidth pattern for 320-pixel modes.
// (R11) Clocking bit 2 reloads serializers every second character, else every character.
// (R12) Clocking bit 3 halves the dot rate, stretching every derived timing.
// (R13) Clocking bit 4 gives one CPU slot per four fetches, else two.
// (R14) Software sets clocking bit 4 above the fast CPU video rate.
// (R15) Plane mask bits gate each plane write strobe.
// (R16) In odd/even mode software keeps plane masks paired equal.
// (R17) Font select bits 1:0 pick the bank when attribute bit three is zero.
// (R18) Font select bits 3:2 pick the bank when attribute bit three is one.
// (R19) Equal selections disable font switching; bit three then means intensity.
// (R20) Reset bit 0 low clears the font select register.
// (R21) Text mode: plane 2 holds fonts, plane 3 unused.
// (R22) Each font bank is 256 characters by 32 lines, 8 Kbytes.
// (R23) CPU slots are inserted between refresh fetches during active display.
// (R24) Memory mode bit 2 low steers even addresses to planes 0, 2.
// (R25) Memory mode bit 0 splits the two memory address buses.
// (R26) Data port accesses with index above four are ignored, reading zero.
module dmsr_regs (
   input wire logic clock,
   input wire logic rst,
   input wire logic [15:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_rd_valid,
   input wire logic misc_io_select,
   input wire logic [1:0] mono_config,
   input wire logic display_active,
   input wire logic cpu_mem_req,
   input wire logic cpu_mem_wr,
   input wire logic cpu_addr0,
   input wire logic attribute_bit_three,
   input wire logic [7:0] char_code,
   input wire logic [4:0] scan_line,
   output logic dot_strobe,
   output logic char_clock,
   output logic serializer_load,
   output logic crt_fetch,
   output logic cpu_grant,
   output logic [3:0] plane_we_n,
   output logic mem_ctrl_oe_n,
   output logic seq_running,
   output logic odd_even_active,
   output logic addr_bus_split,
   output logic font_switch_enable,
   output logic [14:0] font_addr
);
   function automatic logic hit_index(input logic [15:0] a);
      return a == `DMSR_INDEX_PORT;
   endfunction

   function automatic logic hit_data(input logic [15:0] a);
      return a == `DMSR_DATA_PORT;
   endfunction

   logic [2:0] index_q;
   logic [7:0] reset_ctrl_q;
   logic [7:0] clocking_mode_q;
   logic [7:0] plane_mask_q;
   logic [7:0] font_sel_q;
   logic [7:0] memory_mode_q;
   logic [7:0] io_rdata_q;
   logic io_rd_valid_q;
   logic [14:0] font_addr_q;
   logic font_switch_q;
   dmsr_pkg::dmsr_seq_state_type state_q;
   dmsr_pkg::dmsr_seq_state_type state_d;
   logic wr_data;
   logic seq_run;
   logic async_held;
   logic [3:0] arb_we_n;
   logic [7:0] data_rd;

   dmsr_seq_if cfg ();

   assign wr_data = io_wr && hit_data(io_addr); // R1
   assign async_held = !reset_ctrl_q[`DMSR_RST_ASYNC_BIT];

   always_ff @(posedge clock) begin
      if (rst) begin
         index_q <= 3'h0;
      end else if (io_wr && hit_index(io_addr)) begin
         index_q <= io_wdata[2:0]; // R1 R2
      end
   end

   // Pointers 5 to 7 match no register, so writes through them fall away
   always_ff @(posedge clock) begin
      if (rst) begin
         reset_ctrl_q <= `DMSR_RESET_CTRL_RST;
      end else if (wr_data && index_q == `DMSR_IDX_RESET) begin
         reset_ctrl_q <= io_wdata; // R2 R26
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         clocking_mode_q <= `DMSR_CLOCKING_RST;
      end else if (wr_data && index_q == `DMSR_IDX_CLOCKING) begin
         clocking_mode_q <= io_wdata; // R2
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         plane_mask_q <= `DMSR_PLANE_MASK_RST;
      end else if (wr_data && index_q == `DMSR_IDX_PLANE_MASK) begin
         plane_mask_q <= io_wdata; // R2
      end
   end

   // Held clear for as long as the asynchronous reset bit stays low
   always_ff @(posedge clock) begin
      if (rst) begin
         font_sel_q <= `DMSR_FONT_SEL_RST;
      end else if (async_held) begin
         font_sel_q <= 8'h00; // R20
      end else if (wr_data && index_q == `DMSR_IDX_FONT_SEL) begin
         font_sel_q <= io_wdata; // R2
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         memory_mode_q <= `DMSR_MEM_MODE_RST;
      end else if (wr_data && index_q == `DMSR_IDX_MEM_MODE) begin
         memory_mode_q <= io_wdata; // R2
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         dmsr_pkg::DMSR_RUN: begin
            if (async_held) begin
               state_d = dmsr_pkg::DMSR_ASYNC_HALT; // R5
            end else if (!reset_ctrl_q[`DMSR_RST_SYNC_BIT]) begin
               state_d = dmsr_pkg::DMSR_SYNC_HALT; // R6
            end
         end
         dmsr_pkg::DMSR_SYNC_HALT: begin
            if (async_held) begin
               state_d = dmsr_pkg::DMSR_ASYNC_HALT;
            end else if (reset_ctrl_q[`DMSR_RST_SYNC_BIT]) begin
               state_d = dmsr_pkg::DMSR_RUN; // R7
            end
         end
         dmsr_pkg::DMSR_ASYNC_HALT: begin
            if (!async_held) begin
               state_d = reset_ctrl_q[`DMSR_RST_SYNC_BIT] ? dmsr_pkg::DMSR_RUN
                  : dmsr_pkg::DMSR_SYNC_HALT; // R7
            end
         end
         default: begin
            state_d = dmsr_pkg::DMSR_ASYNC_HALT;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= dmsr_pkg::DMSR_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // The asynchronous bit stops the sequence at once, without waiting on the state
   assign seq_run = (state_q == dmsr_pkg::DMSR_RUN) && !async_held; // R5 R7

   assign cfg.run = seq_run;
   assign cfg.dot8 = clocking_mode_q[`DMSR_CM_DOT8_BIT];
   assign cfg.dotdiv = clocking_mode_q[`DMSR_CM_DOTDIV_BIT];
   assign cfg.load2 = clocking_mode_q[`DMSR_CM_LOAD2_BIT];
   assign cfg.crt_low = clocking_mode_q[`DMSR_CM_CRT_LOW_BIT];
   assign cfg.cpu_low = clocking_mode_q[`DMSR_CM_CPU_LOW_BIT];
   assign cfg.odd_even = !memory_mode_q[`DMSR_MM_LINEAR_BIT]; // R24
   assign cfg.plane_mask = plane_mask_q[3:0];

   dmsr_clkgen u_clkgen (
      .clock(clock),
      .rst(rst),
      .cfg(cfg.clk)
   );

   dmsr_memarb u_memarb (
      .clock(clock),
      .rst(rst),
      .cfg(cfg.arb),
      .display_active(display_active),
      .cpu_mem_req(cpu_mem_req),
      .cpu_mem_wr(cpu_mem_wr),
      .cpu_addr0(cpu_addr0),
      .crt_fetch(crt_fetch),
      .cpu_grant(cpu_grant),
      .plane_we_n(arb_we_n)
   );

   always_comb begin
      if (index_q == `DMSR_IDX_RESET) begin
         data_rd = reset_ctrl_q;
      end else if (index_q == `DMSR_IDX_CLOCKING) begin
         data_rd = clocking_mode_q;
      end else if (index_q == `DMSR_IDX_PLANE_MASK) begin
         data_rd = plane_mask_q;
      end else if (index_q == `DMSR_IDX_FONT_SEL) begin
         data_rd = font_sel_q;
      end else if (index_q == `DMSR_IDX_MEM_MODE) begin
         data_rd = memory_mode_q;
      end else begin
         data_rd = 8'h00; // R26
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         io_rdata_q <= 8'h00;
      end else if (io_rd && hit_index(io_addr)) begin
         io_rdata_q <= {mono_config, misc_io_select, 2'h0, index_q}; // R3 R4
      end else if (io_rd && hit_data(io_addr)) begin
         io_rdata_q <= data_rd; // R1
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         io_rd_valid_q <= 1'b0;
      end else begin
         io_rd_valid_q <= io_rd && (hit_index(io_addr) || hit_data(io_addr));
      end
   end

   // Font banks sit in plane 2, each 256 characters of 32 scan lines
   always_ff @(posedge clock) begin
      if (rst) begin
         font_addr_q <= 15'h0000;
      end else begin
         font_addr_q <= {attribute_bit_three ? font_sel_q[3:2] : font_sel_q[1:0],
            char_code, scan_line}; // R17 R18 R21 R22
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         font_switch_q <= 1'b0;
      end else begin
         font_switch_q <= font_sel_q[3:2] != font_sel_q[1:0]; // R19
      end
   end

   assign io_rdata = io_rdata_q;
   assign io_rd_valid = io_rd_valid_q;
   assign dot_strobe = cfg.dot_tick;
   assign char_clock = cfg.char_tick;
   assign serializer_load = cfg.load_tick;
   assign plane_we_n = arb_we_n | {4{async_held}}; // R5 R15
   assign mem_ctrl_oe_n = async_held; // R5
   assign seq_running = seq_run;
   assign odd_even_active = cfg.odd_even;
   assign addr_bus_split = memory_mode_q[`DMSR_MM_SPLIT_BIT]; // R25
   assign font_switch_enable = font_switch_q;
   assign font_addr = font_addr_q;

   // Checking aid: cycles since the last character clock
   logic [4:0] gap_q;
   logic gap_ok_q;
   logic [4:0] gap_want;

   always_ff @(posedge clock) begin
      if (rst || char_clock) begin
         gap_q <= 5'h00;
      end else if (gap_q != 5'h1f) begin
         gap_q <= gap_q + 5'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || !seq_run || (wr_data && index_q == `DMSR_IDX_CLOCKING)) begin
         gap_ok_q <= 1'b0;
      end else if (char_clock) begin
         gap_ok_q <= 1'b1;
      end
   end

   assign gap_want = cfg.dotdiv ? {(cfg.dot8 ? `DMSR_LAST_DOT_NARROW : `DMSR_LAST_DOT_WIDE), 1'b1}
      : {1'b0, (cfg.dot8 ? `DMSR_LAST_DOT_NARROW : `DMSR_LAST_DOT_WIDE)};

   default clocking dc @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_index_load;
      io_wr && hit_index(io_addr);
   endsequence

   sequence s_sync_clear;
      wr_data && index_q == `DMSR_IDX_RESET && !io_wdata[1] && io_wdata[0];
   endsequence

   a_index_load: assert property (s_index_load |=> index_q == $past(io_wdata[2:0])) // R2
      else $error("index pointer not loaded");
   a_index_iosel: assert property (io_rd && hit_index(io_addr)
      |=> io_rd_valid && io_rdata[5] == $past(misc_io_select)) // R3
      else $error("index read lacks address select copy");
   a_index_mono: assert property (io_rd && hit_index(io_addr)
      |=> io_rdata[7:6] == $past(mono_config)) // R4
      else $error("index read lacks monochrome config bits");
   a_async_float: assert property (async_held
      |-> mem_ctrl_oe_n && plane_we_n == 4'hf && !seq_running && !char_clock) // R5
      else $error("outputs active during asynchronous reset");
   a_sync_halt: assert property (s_sync_clear |=> ##2 !seq_running ##1 !char_clock) // R6
      else $error("synchronous reset did not halt");
   a_run_needs_both: assert property (seq_running
      |-> reset_ctrl_q[0] && $past(reset_ctrl_q[1:0]) == 2'h3) // R7
      else $error("running without both reset bits");
   a_char_width: assert property (char_clock && gap_ok_q |-> gap_q == gap_want) // R9 R12
      else $error("character clock width wrong");
   a_load_every: assert property (!clocking_mode_q[2] && char_clock |-> serializer_load) // R11
      else $error("serializer reload missed");
   a_plane_gate: assert property ((~plane_we_n & ~$past(plane_mask_q[3:0])) == 4'h0) // R15
      else $error("write strobe on masked plane");
   a_odd_even: assert property (!$past(memory_mode_q[2]) && !plane_we_n[0]
      |-> plane_we_n[1] && plane_we_n[3]) // R24
      else $error("odd planes written on even address");
   a_font_clear: assert property (async_held |=> font_sel_q == 8'h00) // R20
      else $error("font select not cleared");
   a_font_pick: assert property (font_addr[14:13] == ($past(attribute_bit_three)
      ? $past(font_sel_q[3:2]) : $past(font_sel_q[1:0]))) // R17 R18
      else $error("wrong font bank");
   a_intensity: assert property (font_switch_enable
      == ($past(font_sel_q[3:2]) != $past(font_sel_q[1:0]))) // R19
      else $error("font switch enable wrong");
   a_unmapped_read: assert property (io_rd && hit_data(io_addr) && index_q > 3'h4
      |=> io_rdata == 8'h00) // R26
      else $error("unmapped index read not zero");
endmodule

// ===== logic/dmsr_defines.svh
// Port addresses, register indices, field positions, reset values and counts
`ifndef DMSR_DEFINES_SVH
`define DMSR_DEFINES_SVH
`define DMSR_INDEX_PORT 16'h03c4
`define DMSR_DATA_PORT 16'h03c5
`define DMSR_IDX_RESET 3'h0
`define DMSR_IDX_CLOCKING 3'h1
`define DMSR_IDX_PLANE_MASK 3'h2
`define DMSR_IDX_FONT_SEL 3'h3
`define DMSR_IDX_MEM_MODE 3'h4
`define DMSR_IDX_LAST 3'h4
`define DMSR_RST_ASYNC_BIT 0
`define DMSR_RST_SYNC_BIT 1
`define DMSR_CM_DOT8_BIT 0
`define DMSR_CM_CRT_LOW_BIT 1
`define DMSR_CM_LOAD2_BIT 2
`define DMSR_CM_DOTDIV_BIT 3
`define DMSR_CM_CPU_LOW_BIT 4
`define DMSR_MM_SPLIT_BIT 0
`define DMSR_MM_LINEAR_BIT 2
`define DMSR_IDXRD_IOSEL_BIT 5
`define DMSR_RESET_CTRL_RST 8'h03
`define DMSR_CLOCKING_RST 8'h00
`define DMSR_PLANE_MASK_RST 8'h0f
`define DMSR_FONT_SEL_RST 8'h00
`define DMSR_MEM_MODE_RST 8'h00
`define DMSR_LAST_DOT_NARROW 4'h7
`define DMSR_LAST_DOT_WIDE 4'h8
`define DMSR_SLOT_CPU_A 3'h2
`define DMSR_SLOT_LAST_HIGH 3'h5
`define DMSR_SLOT_LAST_LOW 3'h4
`define DMSR_PLANES_ALL 4'hf
`define DMSR_PLANES_EVEN 4'h5
`define DMSR_PLANES_ODD 4'ha
`endif

// ===== logic/dmsr_pkg.sv
// Types shared by the sequencer register bank
package dmsr_pkg;
   typedef enum logic [2:0] {
      DMSR_RUN = 3'b001,
      DMSR_SYNC_HALT = 3'b010,
      DMSR_ASYNC_HALT = 3'b100
   } dmsr_seq_state_type;
endpackage

// ===== logic/dmsr_seq_if.sv
// Configuration and timing strobes between register bank and sequencer parts
`timescale 1ns/1ps
interface dmsr_seq_if;
   logic run;
   logic dot8;
   logic dotdiv;
   logic load2;
   logic crt_low;
   logic cpu_low;
   logic odd_even;
   logic [3:0] plane_mask;
   logic dot_tick;
   logic char_tick;
   logic load_tick;
   modport ctl (output run, dot8, dotdiv, load2, crt_low, cpu_low, odd_even, plane_mask,
      input dot_tick, char_tick, load_tick);
   modport clk (input run, dot8, dotdiv, load2, output dot_tick, char_tick, load_tick);
   modport arb (input run, crt_low, cpu_low, odd_even, plane_mask, char_tick);
endinterface

// ===== logic/dmsr_clkgen.sv
// Dot clock divider, character clock and serializer reload timing
`timescale 1ns/1ps
`include "dmsr_defines.svh"
module dmsr_clkgen (
   input wire logic clock,
   input wire logic rst,
   dmsr_seq_if.clk cfg
);
   logic dot_phase_q;
   logic [3:0] dot_cnt_q;
   logic char_par_q;
   logic [3:0] last_dot;

   assign last_dot = cfg.dot8 ? `DMSR_LAST_DOT_NARROW : `DMSR_LAST_DOT_WIDE; // R9
   assign cfg.dot_tick = cfg.run && (!cfg.dotdiv || dot_phase_q); // R12
   // Compare with >= so a width change mid-character cannot run past the end
   assign cfg.char_tick = cfg.dot_tick && (dot_cnt_q >= last_dot); // R9
   assign cfg.load_tick = cfg.char_tick && (!cfg.load2 || char_par_q); // R11

   always_ff @(posedge clock) begin
      if (rst || !cfg.run) begin
         dot_phase_q <= 1'b0;
      end else if (cfg.dotdiv) begin
         dot_phase_q <= ~dot_phase_q; // R12
      end else begin
         dot_phase_q <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || !cfg.run) begin
         dot_cnt_q <= 4'h0;
      end else if (cfg.char_tick) begin
         dot_cnt_q <= 4'h0;
      end else if (cfg.dot_tick) begin
         dot_cnt_q <= dot_cnt_q + 4'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || !cfg.run) begin
         char_par_q <= 1'b0;
      end else if (cfg.char_tick) begin
         char_par_q <= ~char_par_q;
      end
   end
endmodule

// ===== logic/dmsr_memarb.sv
// Display memory slot sharing between refresh fetches and CPU accesses
`timescale 1ns/1ps
`include "dmsr_defines.svh"
module dmsr_memarb (
   input wire logic clock,
   input wire logic rst,
   dmsr_seq_if.arb cfg,
   input wire logic display_active,
   input wire logic cpu_mem_req,
   input wire logic cpu_mem_wr,
   input wire logic cpu_addr0,
   output logic crt_fetch,
   output logic cpu_grant,
   output logic [3:0] plane_we_n
);
   logic [2:0] slot_q;
   logic crt_par_q;
   logic crt_fetch_q;
   logic cpu_grant_q;
   logic [3:0] we_n_q;
   logic [2:0] last_slot;
   logic cpu_slot;
   logic crt_go;
   logic cpu_go;
   logic [3:0] plane_sel;

   assign last_slot = cfg.cpu_low ? `DMSR_SLOT_LAST_LOW : `DMSR_SLOT_LAST_HIGH; // R13
   assign cpu_slot = (slot_q == last_slot) || (!cfg.cpu_low && slot_q == `DMSR_SLOT_CPU_A); // R13
   // Low refresh bandwidth skips every other refresh slot
   assign crt_go = cfg.run && cfg.char_tick && display_active && !cpu_slot
      && (!cfg.crt_low || crt_par_q); // R10
   // Outside active display every slot may serve the CPU
   assign cpu_go = cfg.run && cfg.char_tick && cpu_mem_req
      && (cpu_slot || !display_active); // R23
   assign plane_sel = !cfg.odd_even ? `DMSR_PLANES_ALL
      : (cpu_addr0 ? `DMSR_PLANES_ODD : `DMSR_PLANES_EVEN); // R24

   always_ff @(posedge clock) begin
      if (rst || !cfg.run) begin
         slot_q <= 3'h0;
      end else if (cfg.char_tick) begin
         slot_q <= (slot_q >= last_slot) ? 3'h0 : slot_q + 3'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || !cfg.run) begin
         crt_par_q <= 1'b0;
      end else if (cfg.char_tick && display_active && !cpu_slot) begin
         crt_par_q <= ~crt_par_q; // R10
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         crt_fetch_q <= 1'b0;
         cpu_grant_q <= 1'b0;
         we_n_q <= `DMSR_PLANES_ALL;
      end else begin
         crt_fetch_q <= crt_go;
         cpu_grant_q <= cpu_go;
         we_n_q <= (cpu_go && cpu_mem_wr) ? ~(cfg.plane_mask & plane_sel) // R15
            : `DMSR_PLANES_ALL;
      end
   end

   assign crt_fetch = crt_fetch_q;
   assign cpu_grant = cpu_grant_q;
   assign plane_we_n = we_n_q;

   default clocking dc @(posedge clock); endclocking
   default disable iff (rst);

   a_grant_on_slot: assert property (cpu_grant |-> $past(cfg.char_tick) && $past(cpu_mem_req)) // R23
      else $error("cpu grant without slot or request");
   a_fetch_in_display: assert property (crt_fetch |-> $past(display_active) && !cpu_grant) // R13
      else $error("refresh fetch outside display or beside grant");
endmodule

// ===== verif/dmsr_host_model.sv
// Host CPU model driving the indexed sequencer I/O ports
`timescale 1ns/1ps
module dmsr_host_model (
   input wire logic clock,
   output logic [15:0] io_addr,
   output logic io_wr,
   output logic io_rd,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_rd_valid
);
   initial begin
      io_addr = 16'h0000;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
   end
   // One strobe per access; released lines flip so stale values never match
   task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
      @(posedge clock);
      #1;
      io_addr = addr;
      io_wdata = data;
      io_wr = 1'b1;
      @(posedge clock);
      #1;
      io_wr = 1'b0;
      io_addr = ~addr;
      io_wdata = ~data;
   endtask
   // Data and valid are taken in the cycle after the strobe edge
   task automatic io_read(input logic [15:0] addr, output logic [7:0] data,
      output logic vld);
      @(posedge clock);
      #1;
      io_addr = addr;
      io_rd = 1'b1;
      @(posedge clock);
      #1;
      io_rd = 1'b0;
      io_addr = ~addr;
      data = io_rdata;
      vld = io_rd_valid;
   endtask
endmodule

// ===== verif/dmsr_regs_tb.sv
// Self-checking bench for the sequencer register bank
`timescale 1ns/1ps
`include "dmsr_defines.svh"
module dmsr_regs_tb;
   logic clock, rst, misc_io_select, display_active, cpu_mem_req, cpu_mem_wr, cpu_addr0;
   logic attribute_bit_three, io_wr, io_rd, io_rd_valid, dot_strobe, char_clock, vld;
   logic serializer_load, crt_fetch, cpu_grant, mem_ctrl_oe_n, seq_running;
   logic odd_even_active, addr_bus_split, font_switch_enable;
   logic [1:0] mono_config;
   logic [7:0] char_code, io_wdata, io_rdata, rd;
   logic [4:0] scan_line;
   logic [15:0] io_addr;
   logic [3:0] plane_we_n;
   logic [14:0] font_addr;
   logic [7:0] bw_cfg [3] = '{8'h01, 8'h11, 8'h03};
   int bw_g [3] = '{10, 6, 10};
   int bw_f [3] = '{20, 24, 10};
   int mismatches, checks, cycles, g, f, l, c, d, slot_len;
   dmsr_host_model host_u (.clock(clock), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_valid(io_rd_valid));
   dmsr_regs dut_u (.clock(clock), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
      .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_valid(io_rd_valid),
      .misc_io_select(misc_io_select), .mono_config(mono_config),
      .display_active(display_active), .cpu_mem_req(cpu_mem_req), .cpu_mem_wr(cpu_mem_wr),
      .cpu_addr0(cpu_addr0), .attribute_bit_three(attribute_bit_three),
      .char_code(char_code), .scan_line(scan_line), .dot_strobe(dot_strobe),
      .char_clock(char_clock), .serializer_load(serializer_load), .crt_fetch(crt_fetch),
      .cpu_grant(cpu_grant), .plane_we_n(plane_we_n), .mem_ctrl_oe_n(mem_ctrl_oe_n),
      .seq_running(seq_running), .odd_even_active(odd_even_active),
      .addr_bus_split(addr_bus_split), .font_switch_enable(font_switch_enable),
      .font_addr(font_addr));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Ceiling well above the longest expected run
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wreg(input logic [2:0] idx, input logic [7:0] val);
      host_u.io_write(`DMSR_INDEX_PORT, {5'h00, idx});
      host_u.io_write(`DMSR_DATA_PORT, val);
   endtask
   task automatic rreg(input logic [2:0] idx, input logic [7:0] exp);
      host_u.io_write(`DMSR_INDEX_PORT, {5'h00, idx});
      host_u.io_read(`DMSR_DATA_PORT, rd, vld);
      check("read valid", 16'h0001, {15'h0000, vld});
      check("register data", {8'h00, exp}, {8'h00, rd});
   endtask
   task automatic sync_char();
      do @(negedge clock); while (char_clock !== 1'b1);
   endtask
   // Counts slot outcomes across n character clocks
   task automatic slots(input int n);
      sync_char();
      g = 0;
      f = 0;
      l = 0;
      c = 0;
      d = 0;
      slot_len = 0;
      do begin
         @(negedge clock);
         slot_len++;
         d += int'(dot_strobe);
         g += int'(cpu_grant);
         f += int'(crt_fetch);
         l += int'(serializer_load);
         c += int'(char_clock);
      end while (c < n);
   endtask
   task automatic set_clocking(input logic [7:0] val);
      wreg(`DMSR_IDX_RESET, 8'h01);
      wreg(`DMSR_IDX_CLOCKING, val);
      wreg(`DMSR_IDX_RESET, 8'h03);
   endtask
   task automatic mem_write(input logic a0, input logic [3:0] exp);
      @(posedge clock);
      #1;
      cpu_mem_req = 1'b1;
      cpu_mem_wr = 1'b1;
      cpu_addr0 = a0;
      c = 0;
      do begin
         @(negedge clock);
         c++;
      end while (cpu_grant !== 1'b1 && c < 60);
      check("grant seen", 16'h0001, {15'h0000, cpu_grant});
      check("plane strobes", {12'h000, exp}, {12'h000, plane_we_n});
      @(posedge clock);
      #1;
      cpu_mem_req = 1'b0;
   endtask
   initial begin
      rst = 1'b1;
      misc_io_select = 1'b1;
      mono_config = 2'b10;
      display_active = 1'b0;
      cpu_mem_req = 1'b0;
      cpu_mem_wr = 1'b0;
      cpu_addr0 = 1'b0;
      attribute_bit_three = 1'b0;
      char_code = 8'h5a;
      scan_line = 5'h13;
      mismatches = 0;
      checks = 0;
      cycles = 0;
      repeat (4) @(posedge clock);
      #1;
      rst = 1'b0;
      rreg(`DMSR_IDX_RESET, `DMSR_RESET_CTRL_RST);
      rreg(`DMSR_IDX_CLOCKING, `DMSR_CLOCKING_RST);
      rreg(`DMSR_IDX_PLANE_MASK, `DMSR_PLANE_MASK_RST);
      rreg(`DMSR_IDX_FONT_SEL, `DMSR_FONT_SEL_RST);
      rreg(`DMSR_IDX_MEM_MODE, `DMSR_MEM_MODE_RST);
      host_u.io_write(`DMSR_INDEX_PORT, 8'h03);
      host_u.io_read(`DMSR_INDEX_PORT, rd, vld);
      check("index read", 16'h00a3, {8'h00, rd});
      misc_io_select = 1'b0;
      mono_config = 2'b01;
      host_u.io_read(`DMSR_INDEX_PORT, rd, vld);
      check("index read", 16'h0043, {8'h00, rd});
      wreg(3'h5, 8'hff);
      rreg(3'h5, 8'h00);
      rreg(3'h7, 8'h00);
      rreg(`DMSR_IDX_RESET, 8'h03);
      for (int m = 0; m < 4; m++) begin
         set_clocking({4'h0, m[1], 2'b00, m[0]});
         sync_char();
         slots(1);
         check("char gap", (m[0] ? 16'h0008 : 16'h0009) * (m[1] ? 16'h0002 : 16'h0001),
            16'(slot_len));
         check("dots per char", m[0] ? 16'h0008 : 16'h0009, 16'(d));
      end
      for (int b = 0; b < 2; b++) begin
         set_clocking(b ? 8'h05 : 8'h01);
         slots(8);
         check("serializer loads", b ? 16'h0004 : 16'h0008, 16'(l));
      end
      // Master clock stays below the fast CPU mode ceiling
      @(posedge clock);
      #1;
      display_active = 1'b1;
      cpu_mem_req = 1'b1;
      for (int k = 0; k < 3; k++) begin
         set_clocking(bw_cfg[k]);
         slots(30);
         check("cpu slots", 16'(bw_g[k]), 16'(g));
         check("refresh fetches", 16'(bw_f[k]), 16'(f));
      end
      @(posedge clock);
      #1;
      display_active = 1'b0;
      wreg(`DMSR_IDX_RESET, 8'h01);
      repeat (3) @(negedge clock);
      check("running", 16'h0000, {15'h0000, seq_running});
      g = 0;
      repeat (40) begin
         @(negedge clock);
         g += int'(cpu_grant);
      end
      check("halted grants", 16'h0000, 16'(g));
      wreg(`DMSR_IDX_RESET, 8'h03);
      repeat (3) @(negedge clock);
      check("running", 16'h0001, {15'h0000, seq_running});
      @(posedge clock);
      #1;
      cpu_mem_req = 1'b0;
      wreg(`DMSR_IDX_FONT_SEL, 8'h0a);
      wreg(`DMSR_IDX_RESET, 8'h02);
      repeat (2) @(negedge clock);
      check("outputs floated", 16'h0001, {15'h0000, mem_ctrl_oe_n});
      check("strobes idle", 16'h000f, {12'h000, plane_we_n});
      check("running", 16'h0000, {15'h0000, seq_running});
      rreg(`DMSR_IDX_FONT_SEL, 8'h00);
      wreg(`DMSR_IDX_RESET, 8'h03);
      rreg(`DMSR_IDX_FONT_SEL, 8'h00);
      wreg(`DMSR_IDX_FONT_SEL, 8'h05);
      repeat (2) @(negedge clock);
      check("font switch", 16'h0000, {15'h0000, font_switch_enable});
      wreg(`DMSR_IDX_FONT_SEL, 8'h04);
      attribute_bit_three = 1'b1;
      repeat (3) @(negedge clock);
      check("font switch", 16'h0001, {15'h0000, font_switch_enable});
      check("font address", {1'b0, 2'h1, char_code, scan_line}, {1'b0, font_addr});
      @(posedge clock);
      #1;
      attribute_bit_three = 1'b0;
      repeat (3) @(negedge clock);
      check("font address", {1'b0, 2'h0, char_code, scan_line}, {1'b0, font_addr});
      wreg(`DMSR_IDX_MEM_MODE, 8'h04);
      check("odd even", 16'h0000, {15'h0000, odd_even_active});
      wreg(`DMSR_IDX_PLANE_MASK, 8'h05);
      mem_write(1'b1, 4'ha);
      wreg(`DMSR_IDX_MEM_MODE, 8'h01);
      check("bus split", 16'h0001, {15'h0000, addr_bus_split});
      check("odd even", 16'h0001, {15'h0000, odd_even_active});
      wreg(`DMSR_IDX_PLANE_MASK, 8'h0f);
      mem_write(1'b1, 4'h5);
      mem_write(1'b0, 4'ha);
      stop_test();
   end
endmodule
